// [verilog/kms_params.svh]
// kms_params.svh: offsets, field positions, reset values and timing counts
// assumes: included by the keypad scanner package and design files by bare name
`ifndef KMS_PARAMS_SVH
`define KMS_PARAMS_SVH

// register indices; byte address is four times the index
`define KMS_IDX_COLUMN_DRIVE   8'hd1
`define KMS_IDX_ROW_SENSE      8'hd2
`define KMS_IDX_SCAN_TIMING    8'hd3
`define KMS_IDX_CONTROL_STATUS 8'hd4
`define KMS_IDX_ORDER_LOW      8'hd5
`define KMS_IDX_ORDER_HIGH     8'hd6
`define KMS_IDX_MATRIX_SIZE    8'hd7
`define KMS_IDX_CLOCK_CONTROL  8'hd8

// reset values
`define KMS_RST_COLUMN_DRIVE   5'h1f
`define KMS_RST_ROW_SENSE      6'h3f
`define KMS_RST_SCAN_TIMING    8'h00
`define KMS_RST_ORDER_LOW      6'h08
`define KMS_RST_ORDER_HIGH     9'h11a
`define KMS_RST_MATRIX_SIZE    7'h65

// field positions
`define KMS_ST_IRQ_EN_BIT      0
`define KMS_ST_KEY_FLAG_BIT    1
`define KMS_ST_SCAN_EN_BIT     2
`define KMS_ST_BUSY_BIT        3
`define KMS_CLK_TICK_EN_BIT    6
`define KMS_DEB_LSB            2
`define KMS_DEB_MSB            7
`define KMS_ROWIV_LSB          0
`define KMS_ROWIV_MSB          1
`define KMS_SIZE_COL_LSB       0
`define KMS_SIZE_COL_MSB       2
`define KMS_SIZE_ROW_LSB       4
`define KMS_SIZE_ROW_MSB       6

// timing: tick period in microseconds, clock in MHz, debounce step in ticks
`define KMS_CLK_MHZ            50
`define KMS_TICK_PERIOD_US     1000
`define KMS_TICK_CYCLES        (`KMS_CLK_MHZ * `KMS_TICK_PERIOD_US)
`define KMS_DEB_STEP_TICKS     4
`define KMS_DEB_ZERO_TICKS     9'd256
`define KMS_ROWIV_ZERO_TICKS   9'd4

`endif

// [verilog/kms_pkg.sv]
// kms_pkg.sv: types shared by the keypad matrix scanner
// assumes: kms_params.svh sits on the include path
`include "kms_params.svh"

package kms_pkg;

    // scanner sequence states
    typedef enum logic [2:0] {
        KMS_OFF,
        KMS_IDLE,
        KMS_DEB_PRESS,
        KMS_SCAN,
        KMS_WAIT_REL,
        KMS_DEB_REL
    } kms_state_e;

    // latched ahb address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] index;
    } kms_ahb_req_s;

    // scan timing configuration
    typedef struct packed {
        logic [5:0] debounce_interval;
        logic [1:0] row_check_interval;
    } kms_scan_cfg_s;

    // result of one full scan
    typedef struct packed {
        logic [1:0] hits;
        logic [2:0] col;
        logic [2:0] row;
    } kms_scan_res_s;

endpackage

// [verilog/kms_keypad_scanner.sv]
// kms_keypad_scanner.sv: keypad matrix scanner with an ahb-lite register slave
// assumes: row inputs synchronous to hclk with pull-ups, one ahb master,
// single word transfers, zero wait states
//
// How it works
// - five column drives, six row senses
// - scanning off until enable bit set
// - all timing paced by gated 1kHz tick
// - idle drives columns low, waits row low
// - debounce press, recheck, else back idle
// - debounce programmable 4ms to 256ms
// - field N gives 4N ms, zero 256ms
// - one column low while rows checked
// - row check interval 1 to 4ms
// - same timing any order, configured size scanned
// - single hit valid, multiple hits ignored
// - column order programmable, row order fixed
// - valid key stores patterns, raises interrupt
// - scanner changes results only on valid key
// - wait release, debounce it, restart if bouncing
// - disabled scanning shows column register on pins
// - bypass: software drives columns, reads rows live
// - column bit zero drives pin low
// - row bit zero means pin low
// - size register limits scanned rows, columns
`timescale 1ns/1ps
`include "kms_params.svh"

module kms_keypad_scanner #(
    parameter int NCOLS       = 5,
    parameter int NROWS       = 6,
    parameter int TICK_CYCLES = `KMS_TICK_CYCLES
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // keypad matrix
    output logic [NCOLS-1:0] col_out,
    input  wire logic [NROWS-1:0] row_in,
    // keypad event
    output logic             key_irq
);

    // registers
    kms_pkg::kms_state_e   state_reg;
    kms_pkg::kms_ahb_req_s req_reg;
    kms_pkg::kms_scan_cfg_s scan_timing_reg;
    kms_pkg::kms_scan_res_s res_reg;
    logic [NCOLS-1:0]      keypad_column_drive;
    logic [NROWS-1:0]      keypad_row_sense;
    logic [5:0]            column_order_low;
    logic [8:0]            column_order_high;
    logic [6:0]            matrix_size_reg;
    logic                  keypad_tick_enable;
    logic                  hw_scan_enable;
    logic                  irq_enable_reg;
    logic                  key_flag_reg;
    logic [14:0]           order_cur_reg;
    logic [2:0]            slot_reg;
    logic [2:0]            row_reg;
    logic [8:0]            timer_reg;
    logic [31:0]           tick_cnt_reg;
    logic                  tick_reg;

    // combinational helpers
    logic                  addr_take;
    logic                  wr_en;
    logic                  any_row_low;
    logic                  tmr_done;
    logic [NROWS-1:0]      row_mask;
    logic [2:0]            ncols;
    logic [2:0]            nrows;
    logic [2:0]            cur_col;
    logic                  valid_key;
    logic                  last_row;
    logic                  last_slot;
    logic [31:0]           rd_value;

    // debounce interval in ticks: N times 4, zero meaning 256
    function automatic logic [8:0] deb_ticks(input logic [5:0] n);
        if (n == 6'h00)
            deb_ticks = `KMS_DEB_ZERO_TICKS;
        else
            deb_ticks = 9'({n, 2'b00});
    endfunction

    // row check interval in ticks: 1,2,3 as coded, zero meaning 4
    function automatic logic [8:0] row_ticks(input logic [1:0] v);
        if (v == 2'b00)
            row_ticks = `KMS_ROWIV_ZERO_TICKS;
        else
            row_ticks = {7'h00, v};
    endfunction

    // active-low pattern with one line low
    function automatic logic [7:0] one_low(input logic [2:0] idx);
        one_low = ~(8'h01 << idx);
    endfunction

    assign addr_take   = hsel && hready && htrans[1];
    assign wr_en       = req_reg.valid && req_reg.write;
    assign ncols       = matrix_size_reg[`KMS_SIZE_COL_MSB:`KMS_SIZE_COL_LSB];
    assign nrows       = matrix_size_reg[`KMS_SIZE_ROW_MSB:`KMS_SIZE_ROW_LSB];
    assign tmr_done    = tick_reg && (timer_reg == 9'd1);
    assign cur_col     = 3'(order_cur_reg >> (slot_reg * 3));
    assign valid_key   = (res_reg.hits == 2'd1);
    assign last_row    = (row_reg == nrows - 3'd1) || (row_reg == 3'(NROWS - 1));
    assign last_slot   = (slot_reg == ncols - 3'd1) || (slot_reg == 3'(NCOLS - 1));

    // unused rows beyond the configured size are masked off
    genvar g;
    generate
        for (g = 0; g < NROWS; g++)
        begin : g_row_mask
            assign row_mask[g] = (3'(g) < nrows);
        end
    endgenerate

    assign any_row_low = |(~row_in & row_mask);

    // gated 1kHz tick divider
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tick_cnt_reg <= 32'h0;
            tick_reg     <= 1'b0;
        end
        else if (!keypad_tick_enable)
        begin
            tick_cnt_reg <= 32'h0;
            tick_reg     <= 1'b0;
        end
        else if (tick_cnt_reg == 32'(TICK_CYCLES - 1))
        begin
            tick_cnt_reg <= 32'h0;
            tick_reg     <= 1'b1;
        end
        else
        begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
            tick_reg     <= 1'b0;
        end
    end

    // ahb address phase capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            req_reg <= '0;
        else if (hready)
        begin
            req_reg.valid <= addr_take;
            req_reg.write <= hwrite;
            req_reg.index <= haddr[9:2];
        end
    end

    // read multiplexer
    always_comb
    begin
        rd_value = 32'h0;
        case (haddr[9:2])
            `KMS_IDX_COLUMN_DRIVE:   rd_value = 32'(keypad_column_drive);
            `KMS_IDX_ROW_SENSE:      rd_value = hw_scan_enable ? 32'(keypad_row_sense)
                                                               : 32'(row_in);
            `KMS_IDX_SCAN_TIMING:    rd_value = 32'(scan_timing_reg);
            `KMS_IDX_CONTROL_STATUS: rd_value = 32'({state_reg != kms_pkg::KMS_IDLE
                                                     && state_reg != kms_pkg::KMS_OFF,
                                                     hw_scan_enable, key_flag_reg,
                                                     irq_enable_reg});
            `KMS_IDX_ORDER_LOW:      rd_value = 32'(column_order_low);
            `KMS_IDX_ORDER_HIGH:     rd_value = 32'(column_order_high);
            `KMS_IDX_MATRIX_SIZE:    rd_value = 32'(matrix_size_reg);
            `KMS_IDX_CLOCK_CONTROL:  rd_value = 32'({keypad_tick_enable, 6'h00});
            default:                 rd_value = 32'h0;
        endcase
    end

    // ahb response, read data registered at the address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_take && !hwrite)
                hrdata <= rd_value;
        end
    end

    // plain configuration registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            scan_timing_reg    <= `KMS_RST_SCAN_TIMING;
            column_order_low   <= `KMS_RST_ORDER_LOW;
            column_order_high  <= `KMS_RST_ORDER_HIGH;
            matrix_size_reg    <= `KMS_RST_MATRIX_SIZE;
            keypad_tick_enable <= 1'b0;
            hw_scan_enable     <= 1'b0;
            irq_enable_reg     <= 1'b0;
        end
        else if (wr_en)
        begin
            case (req_reg.index)
                `KMS_IDX_SCAN_TIMING:    scan_timing_reg   <= hwdata[7:0];
                `KMS_IDX_ORDER_LOW:      column_order_low  <= hwdata[5:0];
                `KMS_IDX_ORDER_HIGH:     column_order_high <= hwdata[8:0];
                `KMS_IDX_MATRIX_SIZE:    matrix_size_reg   <= hwdata[6:0];
                `KMS_IDX_CLOCK_CONTROL:  keypad_tick_enable <= hwdata[`KMS_CLK_TICK_EN_BIT];
                `KMS_IDX_CONTROL_STATUS:
                begin
                    hw_scan_enable <= hwdata[`KMS_ST_SCAN_EN_BIT];
                    irq_enable_reg <= hwdata[`KMS_ST_IRQ_EN_BIT];
                end
                default: ;
            endcase
        end
    end

    // scanner sequence
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg     <= kms_pkg::KMS_OFF;
            order_cur_reg <= 15'h0;
            slot_reg      <= 3'h0;
            row_reg       <= 3'h0;
            timer_reg     <= 9'h0;
            res_reg       <= '0;
        end
        else if (!hw_scan_enable)
            state_reg <= kms_pkg::KMS_OFF;
        else
        begin
            if (tick_reg && timer_reg != 9'd0)
                timer_reg <= timer_reg - 9'd1;
            case (state_reg)
                kms_pkg::KMS_OFF:
                    state_reg <= kms_pkg::KMS_IDLE;
                kms_pkg::KMS_IDLE:
                begin
                    if (any_row_low)
                    begin
                        timer_reg <= deb_ticks(scan_timing_reg.debounce_interval);
                        state_reg <= kms_pkg::KMS_DEB_PRESS;
                    end
                end
                kms_pkg::KMS_DEB_PRESS:
                begin
                    if (tmr_done && !any_row_low)
                        state_reg <= kms_pkg::KMS_IDLE;
                    else if (tmr_done)
                    begin
                        order_cur_reg <= {column_order_high, column_order_low};
                        slot_reg      <= 3'h0;
                        row_reg       <= 3'h0;
                        res_reg       <= '0;
                        timer_reg     <= row_ticks(scan_timing_reg.row_check_interval);
                        state_reg     <= kms_pkg::KMS_SCAN;
                    end
                end
                kms_pkg::KMS_SCAN:
                begin
                    if (tmr_done)
                    begin
                        // count closures; a second one saturates as invalid
                        if (!row_in[row_reg] && res_reg.hits != 2'd2)
                        begin
                            res_reg.hits <= res_reg.hits + 2'd1;
                            res_reg.col  <= cur_col;
                            res_reg.row  <= row_reg;
                        end
                        timer_reg <= row_ticks(scan_timing_reg.row_check_interval);
                        if (!last_row)
                            row_reg <= row_reg + 3'd1;
                        else if (!last_slot)
                        begin
                            row_reg  <= 3'h0;
                            slot_reg <= slot_reg + 3'd1;
                        end
                        else
                            state_reg <= kms_pkg::KMS_WAIT_REL;
                    end
                end
                kms_pkg::KMS_WAIT_REL:
                begin
                    if (!any_row_low)
                    begin
                        timer_reg <= deb_ticks(scan_timing_reg.debounce_interval);
                        state_reg <= kms_pkg::KMS_DEB_REL;
                    end
                end
                kms_pkg::KMS_DEB_REL:
                begin
                    if (any_row_low)
                        timer_reg <= deb_ticks(scan_timing_reg.debounce_interval);
                    else if (tmr_done)
                        state_reg <= kms_pkg::KMS_IDLE;
                end
                default:
                    state_reg <= kms_pkg::KMS_OFF;
            endcase
        end
    end

    // result registers: software writes the column drive, scanner overwrites both on a valid key
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            keypad_column_drive <= `KMS_RST_COLUMN_DRIVE;
            keypad_row_sense    <= `KMS_RST_ROW_SENSE;
        end
        else if (hw_scan_enable && state_reg == kms_pkg::KMS_SCAN && tmr_done
                 && last_row && last_slot)
        begin
            // the last sample joins the count in the same cycle
            if ((valid_key && row_in[row_reg])
                || (res_reg.hits == 2'd0 && !row_in[row_reg]))
            begin
                keypad_column_drive <= valid_key ? NCOLS'(one_low(res_reg.col))
                                                 : NCOLS'(one_low(cur_col));
                keypad_row_sense    <= valid_key ? NROWS'(one_low(res_reg.row))
                                                 : NROWS'(one_low(row_reg));
            end
        end
        else if (wr_en && req_reg.index == `KMS_IDX_COLUMN_DRIVE)
            keypad_column_drive <= hwdata[NCOLS-1:0];
    end

    // sticky key flag, a new key wins over a clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            key_flag_reg <= 1'b0;
        else if (hw_scan_enable && state_reg == kms_pkg::KMS_SCAN && tmr_done
                 && last_row && last_slot
                 && ((valid_key && row_in[row_reg])
                     || (res_reg.hits == 2'd0 && !row_in[row_reg])))
            key_flag_reg <= 1'b1;
        else if (wr_en && req_reg.index == `KMS_IDX_CONTROL_STATUS
                 && hwdata[`KMS_ST_KEY_FLAG_BIT])
            key_flag_reg <= 1'b0;
    end

    // column pins and interrupt line
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            col_out <= `KMS_RST_COLUMN_DRIVE;
            key_irq <= 1'b0;
        end
        else
        begin
            key_irq <= key_flag_reg && irq_enable_reg;
            case (state_reg)
                kms_pkg::KMS_IDLE, kms_pkg::KMS_DEB_PRESS,
                kms_pkg::KMS_WAIT_REL, kms_pkg::KMS_DEB_REL:
                    col_out <= '0;
                kms_pkg::KMS_SCAN:
                    col_out <= NCOLS'(one_low(cur_col));
                default:
                    col_out <= keypad_column_drive;
            endcase
            if (!hw_scan_enable)
                col_out <= keypad_column_drive;
        end
    end

endmodule

// [tb/kms_keypad_model.sv]
// kms_keypad_model.sv: switch matrix standing behind the scanner pins
// assumes: the bench closes switches, open rows sit at their pull-up level
`timescale 1ns/1ps
module kms_keypad_model (
    // column drives from the scanner
    input  wire logic [4:0]  col_out,
    // closed switches, bit column*6+row
    input  wire logic [29:0] closed,
    // row senses back to the scanner
    output logic      [5:0]  row_in
);
    // a row goes low only through a closed switch on a low column
    always_comb
    begin
        row_in = 6'h3f;
        for (int k = 0; k < 30; k++)
        begin
            if (closed[k] && !col_out[k / 6])
                row_in[k % 6] = 1'b0;
        end
    end
endmodule

// [tb/kms_keypad_scanner_asserts.sv]
// kms_keypad_scanner_asserts.sv: column and interrupt pin checks for the keypad scanner
// assumes: bound into kms_keypad_scanner, control bits shadowed from bus writes
`timescale 1ns/1ps
module kms_keypad_scanner_asserts #(
    parameter int NCOLS       = 5,
    parameter int NROWS       = 6,
    parameter int TICK_CYCLES = 4
) (
    // clock, reset and bus
    input wire logic             hclk,
    input wire logic             hresetn,
    input wire logic             hsel,
    input wire logic [31:0]      haddr,
    input wire logic [1:0]       htrans,
    input wire logic             hwrite,
    input wire logic [31:0]      hwdata,
    input wire logic             hready,
    input wire logic             hreadyout,
    input wire logic [31:0]      hrdata,
    input wire logic             hresp,
    // keypad pins and event
    input wire logic [NCOLS-1:0] col_out,
    input wire logic [NROWS-1:0] row_in,
    input wire logic             key_irq
);
    logic       dph_reg, dwr_reg, sen_reg, ien_reg, w1, w4;
    logic [7:0] idx_reg;
    logic [4:0] col_reg;

    // data-phase writes to column drive and control
    assign w1 = dph_reg && dwr_reg && idx_reg == 8'hd1;
    assign w4 = dph_reg && dwr_reg && idx_reg == 8'hd4;

    // shadow of scan enable and interrupt enable
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dph_reg <= 1'b0;
            sen_reg <= 1'b0;
            ien_reg <= 1'b0;
        end
        else
        begin
            dph_reg <= hready && hsel && htrans[1];
            if (w4)
            begin
                sen_reg <= hwdata[2];
                ien_reg <= hwdata[0];
            end
        end
    end

    // address capture and last written column pattern
    always_ff @(posedge hclk)
    begin
        dwr_reg <= hwrite;
        idx_reg <= haddr[9:2];
        if (w1)
            col_reg <= hwdata[4:0];
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_reset_cols: assert property ($rose(hresetn) |-> col_out == 5'h1f)
        else $error("columns not all high after reset");
    a_idle_low: assert property (($rose(sen_reg) && row_in == 6'h3f) |-> ##[1:3] col_out == 5'h00)
        else $error("idle scan does not drive all columns low");
    a_one_col: assert property ((sen_reg && $past(sen_reg) && $past(sen_reg, 2) && $past(sen_reg, 3))
        |-> (col_out == 5'h00 || col_out == 5'h1f || $onehot(~col_out)))
        else $error("more than one column low during scan");
    a_off_stable: assert property ((!sen_reg && !$past(sen_reg) && !$past(sen_reg, 2) && !w1
        && !$past(w1) && !$past(w1, 2)) |-> $stable(col_out))
        else $error("columns moved while scanning is off");
    a_col_write: assert property ((w1 && !sen_reg) |-> ##[1:2] col_out == col_reg)
        else $error("bypass column write not on the pins");
    a_irq_enable: assert property (key_irq |-> (ien_reg || $past(ien_reg)))
        else $error("key event without interrupt enable");
    a_irq_sticky: assert property ($fell(key_irq) |-> ($past(w4) || $past(w4, 2) || $past(w4, 3)))
        else $error("key event dropped without a control write");
    a_irq_clear: assert property ((w4 && hwdata[1] && row_in == 6'h3f) |-> ##[1:2] !key_irq)
        else $error("key event not cleared");
endmodule

bind kms_keypad_scanner kms_keypad_scanner_asserts #(.NCOLS(NCOLS), .NROWS(NROWS),
    .TICK_CYCLES(TICK_CYCLES)) kms_chk_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .col_out(col_out),
    .row_in(row_in), .key_irq(key_irq));

// [tb/tb.sv]
// tb.sv: self-checking bench for the keypad matrix scanner
// assumes: zero wait-state register slave, switch model on the column and row pins
`timescale 1ns/1ps
module tb;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        hreadyout, hresp, key_irq;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv, seed = 32'h7f03;
    logic [4:0]  col_out, w;
    logic [5:0]  row_in;
    logic [29:0] keys = 30'h0;
    int          n_errors = 0, check_count = 0, cyc = 0, n, c, r;
    logic [31:0] rst_tab [9] = '{32'h1f, 32'h3f, 32'h0, 32'h0, 32'h08, 32'h11a, 32'h65,
                                 32'h0, 32'h0};
    logic [31:0] byp_tab [3] = '{32'h1e, 32'h0f, 32'h1f};

    // design with its ready looped back, and the switch matrix
    kms_keypad_scanner #(.NCOLS(5), .NROWS(6), .TICK_CYCLES(4)) kms_keypad_scanner_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .col_out(col_out),
        .row_in(row_in), .key_irq(key_irq));
    kms_keypad_model kms_keypad_model_inst (.col_out(col_out), .closed(keys), .row_in(row_in));

    // 50 MHz clock
    initial
    begin
        forever #10 hclk = ~hclk;
    end

    // hang guard
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_errors++;
            summarize();
        end
    end

    // verdict and end of run
    task automatic summarize();
        if (n_errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one comparison
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one single-word transfer, read data taken at the data-phase edge
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rdv);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'b00};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rdv = hrdata;
        chk("okay", {hreadyout, hresp}, 32'h2);
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // pattern with column cc alone low
    function automatic logic [31:0] col_exp(input int cc);
        return {27'h0, ~(5'h01 << cc)};
    endfunction

    // row sense for one key at cc, rr with columns driven as cols
    function automatic logic [31:0] row_exp(input logic [4:0] cols, input int cc, input int rr);
        return cols[cc] ? 32'h3f : {26'h0, ~(6'h01 << rr)};
    endfunction

    // main sequence
    initial
    begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        chk("col_reset", col_out, 32'h1f);
        bus(1'b1, 8'hd9, 32'hff, rv);
        for (int i = 0; i < 9; i++)
        begin
            bus(1'b0, 8'hd1 + 8'(i), 32'h0, rv);
            chk("reset_val", rv, rst_tab[i]);
        end
        bus(1'b1, 8'hd4, 32'h5, rv);
        repeat (4) @(posedge hclk);
        chk("idle_cols", col_out, 32'h0);
        // single keys: random, first corner, last corner with reversed order
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            c = (i == 1) ? 0 : (i == 2) ? 4 : seed % 5;
            r = (i == 1) ? 0 : (i == 2) ? 5 : seed[15:8] % 6;
            if (i == 2)
            begin
                bus(1'b1, 8'hd5, 32'h1c, rv);
                bus(1'b1, 8'hd6, 32'h00a, rv);
                bus(1'b1, 8'hd3, 32'h06, rv);
            end
            keys <= 30'h1 << (c * 6 + r);
            if (i == 0)
            begin
                repeat (300) @(posedge hclk);
                chk("tick_off", key_irq, 32'h0);
                bus(1'b1, 8'hd8, 32'h40, rv);
            end
            n = 0;
            while (key_irq !== 1'b1 && n < 3000)
            begin
                @(posedge hclk);
                n++;
            end
            chk("irq", key_irq, 32'h1);
            chk("latency", (i == 0) ? n >= 1024 : n < 400, 32'h1);
            bus(1'b0, 8'hd1, 32'h0, rv);
            chk("key_col", rv, col_exp(c));
            bus(1'b0, 8'hd2, 32'h0, rv);
            chk("key_row", rv, {26'h0, ~(6'h01 << r)});
            bus(1'b0, 8'hd4, 32'h0, rv);
            chk("key_flag", rv[1], 32'h1);
            chk("busy", rv[3], 32'h1);
            keys <= 30'h0;
            repeat (40) @(posedge hclk);
            bus(1'b1, 8'hd4, 32'h7, rv);
            repeat (2) @(posedge hclk);
            chk("irq_clear", key_irq, 32'h0);
            if (i == 0)
                bus(1'b1, 8'hd3, 32'h05, rv);
            repeat (1200) @(posedge hclk);
        end
        // two keys in different columns give no result
        keys <= 30'h1 | (30'h1 << 27);
        repeat (400) @(posedge hclk);
        chk("two_keys", key_irq, 32'h0);
        bus(1'b0, 8'hd1, 32'h0, rv);
        chk("kept_col", rv, col_exp(c));
        keys <= 30'h0;
        repeat (200) @(posedge hclk);
        // column 0, fifth in the reversed order, lies beyond the configured size and is skipped
        bus(1'b1, 8'hd7, 32'h54, rv);
        keys <= 30'h1;
        repeat (400) @(posedge hclk);
        chk("size_skip", key_irq, 32'h0);
        keys <= 30'h0;
        repeat (200) @(posedge hclk);
        // turn scanning off mid-scan
        keys <= 30'h1 << 14;
        repeat (60) @(posedge hclk);
        bus(1'b1, 8'hd4, 32'h1, rv);
        repeat (3) @(posedge hclk);
        chk("off_cols", col_out, col_exp(c));
        // bypass: software drives columns and reads live rows
        for (int j = 0; j < 8; j++)
        begin
            seed = lfsr(seed);
            w = (j < 3) ? byp_tab[j][4:0] : seed[4:0];
            c = seed[12:8] % 5;
            r = seed[23:16] % 6;
            keys <= 30'h1 << (c * 6 + r);
            bus(1'b1, 8'hd1, {27'h0, w}, rv);
            repeat (2) @(posedge hclk);
            chk("byp_col", col_out, {27'h0, w});
            bus(1'b0, 8'hd2, 32'h0, rv);
            chk("byp_row", rv, row_exp(w, c, r));
        end
        summarize();
    end
endmodule
